// file: include/rcd_pkg.sv
// constants, encodings and types shared by the core and its arithmetic unit
package rcd_pkg;
   // timing: one instruction cycle holds this many oscillator phases
   localparam int RCD_CLK_MHZ       = 40;
   localparam int RCD_REF_OSC_MHZ   = 20;
   localparam int RCD_REF_INSTR_NS  = 200;
   localparam int RCD_PHASES        = RCD_REF_INSTR_NS * RCD_REF_OSC_MHZ / 1000;

   // widths of the two independent buses
   localparam int RCD_IW  = 14;
   localparam int RCD_DW  = 8;
   localparam int RCD_PCW = 13;
   localparam int RCD_AW  = 8;

   // instruction layout
   localparam int         RCD_OP_HI   = 13;
   localparam int         RCD_OP_LO   = 8;
   localparam int         RCD_DEST    = 7;
   localparam logic [2:0] RCD_GOTO_PX = 3'h5;

   // opcodes, byte-oriented (file) group
   localparam logic [5:0] OP_MOVWF = 6'h00;
   localparam logic [5:0] OP_CLR   = 6'h01;
   localparam logic [5:0] OP_SUBWF = 6'h02;
   localparam logic [5:0] OP_DEC   = 6'h03;
   localparam logic [5:0] OP_IOR   = 6'h04;
   localparam logic [5:0] OP_AND   = 6'h05;
   localparam logic [5:0] OP_XOR   = 6'h06;
   localparam logic [5:0] OP_ADD   = 6'h07;
   localparam logic [5:0] OP_MOVF  = 6'h08;
   localparam logic [5:0] OP_COM   = 6'h09;
   localparam logic [5:0] OP_INC   = 6'h0A;
   localparam logic [5:0] OP_RRF   = 6'h0B;
   localparam logic [5:0] OP_RLF   = 6'h0C;
   localparam logic [5:0] OP_SWAP  = 6'h0D;
   // literal group
   localparam logic [5:0] OP_MOVLW = 6'h10;
   localparam logic [5:0] OP_IORLW = 6'h11;
   localparam logic [5:0] OP_ANDLW = 6'h12;
   localparam logic [5:0] OP_XORLW = 6'h13;
   localparam logic [5:0] OP_SUBLW = 6'h14;
   localparam logic [5:0] OP_ADDLW = 6'h15;
   localparam logic [13:0] RCD_NOP = 14'h0E00;

   // special function register addresses, same in both banks
   localparam logic [6:0] ADR_INDF   = 7'h00;
   localparam logic [6:0] ADR_PCL    = 7'h02;
   localparam logic [6:0] ADR_STATUS = 7'h03;
   localparam logic [6:0] ADR_FSR    = 7'h04;
   localparam logic [6:0] ADR_PCLATH = 7'h0A;

   // status register fields and reset values
   localparam int         ST_C    = 0;
   localparam int         ST_DC   = 1;
   localparam int         ST_Z    = 2;
   localparam int         ST_BANK = 5;
   localparam logic [7:0]  RCD_STATUS_RST = 8'h00;
   localparam logic [12:0] RCD_PC_RST     = 13'h0000;

   typedef enum logic [1:0] {
      RCD_PH1 = 2'h0,
      RCD_PH2 = 2'h1,
      RCD_PH3 = 2'h3,
      RCD_PH4 = 2'h2
   } rcd_phase_t;

   typedef enum logic [3:0] {
      ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_PASSB, ALU_PASSA,
      ALU_COM, ALU_INC, ALU_DEC, ALU_RRF, ALU_RLF, ALU_SWAP, ALU_CLR
   } rcd_alu_op_t;

   typedef struct packed {
      rcd_alu_op_t op;
      logic        lit;
      logic        rd;
      logic        to_f;
      logic        to_w;
      logic        fc;
      logic        fdc;
      logic        fz;
      logic        jump;
   } rcd_dec_t;
endpackage

// file: hdl/rcd_alu.sv
// 8-bit two's complement arithmetic and logic unit
`timescale 1ns/1ps
module rcd_alu import rcd_pkg::*; (
   input rcd_alu_op_t op,
   input logic [7:0] a,
   input logic [7:0] b,
   input logic       c_in,
   output logic [7:0] y,
   output logic       c_out,
   output logic       dc_out,
   output logic       z_out
);
   logic [8:0] sum;
   logic [4:0] nib;

   // a is the accumulator, b the file or literal operand
   always_comb begin
      sum = {1'b0, a} + {1'b0, b};
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      y = b;
      c_out = c_in;
      dc_out = 1'b0;
      case (op)
         ALU_ADD: begin
            y = sum[7:0];
            c_out = sum[8];
            dc_out = nib[4];
         end
         ALU_SUB: begin
            y = b - a;
            c_out = (b >= a);                 // set means no borrow
            dc_out = (b[3:0] >= a[3:0]);      // set means no nibble borrow
         end
         ALU_AND:   y = a & b;
         ALU_IOR:   y = a | b;
         ALU_XOR:   y = a ^ b;
         ALU_PASSB: y = b;
         ALU_PASSA: y = a;
         ALU_COM:   y = ~b;
         ALU_INC:   y = b + 8'h01;
         ALU_DEC:   y = b - 8'h01;
         ALU_RRF: begin
            y = {c_in, b[7:1]};
            c_out = b[0];
         end
         ALU_RLF: begin
            y = {b[6:0], c_in};
            c_out = b[7];
         end
         ALU_SWAP:  y = {b[3:0], b[7:4]};
         ALU_CLR:   y = 8'h00;
         default:   y = b;
      endcase
      z_out = (y == 8'h00);
   end
endmodule

// file: hdl/rcd_core.sv
// microcontroller core: four-phase sequencer, two-stage pipeline, register file access
//
// Functional notes
// RULE_01: program fetch and data access use separate buses, concurrently in one cycle.
// RULE_02: every instruction is one 14-bit word fetched whole in one cycle.
// RULE_03: next fetch overlaps current execution; one instruction per instruction cycle.
// RULE_04: special registers, program counter included, sit in the data address space.
// RULE_05: any operation works on any register, directly or through the pointer.
// RULE_06: 8-bit unit does add, subtract, shift and logic with accumulator.
// RULE_07: arithmetic is two's complement.
// RULE_08: two-operand forms use accumulator plus file register or literal.
// RULE_09: single-operand forms act on accumulator or one file register.
// RULE_10: accumulator is 8 bits and has no data address.
// RULE_11: carry, digit carry, zero updated per instruction; otherwise left alone.
// RULE_12: in subtraction carry and digit carry report borrows, active low.
// RULE_13: in RC mode the clock output runs at a quarter of oscillator rate.
// RULE_14: master clear held low keeps the core in reset.
// RULE_15: four phases per cycle; counter steps in phase one, fetch latched phase four.
// RULE_16: operand read in phase two, destination written in phase four.
// RULE_17: a change of program counter costs two cycles; prefetched word is dropped.
// RULE_18: zero flag set on an all-zero result, cleared otherwise.
`timescale 1ns/1ps
module rcd_core import rcd_pkg::*; (
   input  logic        clk,
   input  logic        sys_rst,
   input  logic        master_clear_n,
   input  logic        rc_mode,
   input  logic [13:0] prog_data,
   input  logic [7:0]  data_rdata,
   output logic [12:0] prog_addr,
   output logic [7:0]  data_addr,
   output logic        data_rd_en,
   output logic        data_wr_en,
   output logic [7:0]  data_wdata,
   output logic        instruction_rate_clock_out,
   output logic [7:0]  acc_out,
   output logic [7:0]  status_out
);
   typedef struct packed {
      rcd_phase_t  q;
      logic        master_clear_n_s1;
      logic        master_clear_n_s2;
      logic [12:0] pc;
      logic [13:0] ir;
      logic [7:0]  w;
      logic [7:0]  status;
      logic [7:0]  fsr;
      logic [4:0]  pclath;
      logic [12:0] paddr;
      logic [7:0]  daddr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
      logic [7:0]  res;
      logic        c;
      logic        dc;
      logic        z;
      logic        ck;
   } rcd_core_state_t;

   localparam rcd_core_state_t CORE_RST = '{q: RCD_PH1, pc: RCD_PC_RST, ir: RCD_NOP,
                                             status: RCD_STATUS_RST, default: '0};

   rcd_core_state_t st_reg;
   rcd_core_state_t st_next;
   rcd_dec_t        d;
   logic [7:0]      ea;
   logic            ext;
   logic [7:0]      sfr_val;
   logic [7:0]      opnd;
   logic [7:0]      alu_y;
   logic            alu_c;
   logic            alu_dc;
   logic            alu_z;
   logic            pcl_wr;
   logic            phase_one;
   logic            phase_two;
   logic            phase_three;
   logic            phase_four;

   // sets the unit operation and the {carry, digit carry, zero} update mask together
   function automatic rcd_dec_t rcd_pick(input rcd_dec_t r, input rcd_alu_op_t op,
                                         input logic [2:0] f);
      rcd_dec_t t;
      t = r;
      t.op = op;
      t.fc = f[2];
      t.fdc = f[1];
      t.fz = f[0];
      return t;
   endfunction

   // instruction decode; the 14-bit word carries all operands
   function automatic rcd_dec_t rcd_decode(input logic [13:0] i);
      rcd_dec_t r;
      r = '{op: ALU_PASSB, default: '0};
      r.to_f = i[RCD_DEST];
      r.to_w = !i[RCD_DEST];
      r.rd = 1'b1;
      if (i[13:11] == RCD_GOTO_PX) begin
         r.jump = 1'b1;
         r.to_f = 1'b0;
         r.to_w = 1'b0;
         r.rd = 1'b0;
      end else begin
         case (i[RCD_OP_HI:RCD_OP_LO])
            OP_MOVWF: begin
               r.op = ALU_PASSA;
               r.to_f = 1'b1;
               r.to_w = 1'b0;
               r.rd = 1'b0;
            end
            OP_CLR: begin
               r.op = ALU_CLR;
               r.rd = 1'b0;
               r.fz = 1'b1;
            end
            OP_SUBWF: r = rcd_pick(r, ALU_SUB, 3'h7);
            OP_ADD:   r = rcd_pick(r, ALU_ADD, 3'h7);
            OP_DEC:   r = rcd_pick(r, ALU_DEC, 3'h1);
            OP_INC:   r = rcd_pick(r, ALU_INC, 3'h1);
            OP_IOR:   r = rcd_pick(r, ALU_IOR, 3'h1);
            OP_AND:   r = rcd_pick(r, ALU_AND, 3'h1);
            OP_XOR:   r = rcd_pick(r, ALU_XOR, 3'h1);
            OP_MOVF:  r = rcd_pick(r, ALU_PASSB, 3'h1);
            OP_COM:   r = rcd_pick(r, ALU_COM, 3'h1);
            OP_RRF:   r = rcd_pick(r, ALU_RRF, 3'h4);
            OP_RLF:   r = rcd_pick(r, ALU_RLF, 3'h4);
            OP_SWAP:  r.op = ALU_SWAP;
            OP_MOVLW, OP_IORLW, OP_ANDLW, OP_XORLW, OP_SUBLW, OP_ADDLW: begin
               r.lit = 1'b1;
               r.rd = 1'b0;
               r.to_f = 1'b0;
               r.to_w = 1'b1;
               case (i[RCD_OP_HI:RCD_OP_LO])
                  OP_IORLW: r = rcd_pick(r, ALU_IOR, 3'h1);
                  OP_ANDLW: r = rcd_pick(r, ALU_AND, 3'h1);
                  OP_XORLW: r = rcd_pick(r, ALU_XOR, 3'h1);
                  OP_SUBLW: r = rcd_pick(r, ALU_SUB, 3'h7);
                  OP_ADDLW: r = rcd_pick(r, ALU_ADD, 3'h7);
                  default:  r.op = ALU_PASSB;
               endcase
            end
            default: begin
               r.to_f = 1'b0;
               r.to_w = 1'b0;
               r.rd = 1'b0;
            end
         endcase
      end
      return r;
   endfunction

   // true for addresses served by the core's own special registers
   function automatic logic rcd_sfr_hit(input logic [6:0] a);
      return (a == ADR_INDF) || (a == ADR_PCL) || (a == ADR_STATUS) ||
             (a == ADR_FSR) || (a == ADR_PCLATH);
   endfunction

   // operand addressing: the pointer register stands in for address zero
   assign d = rcd_decode(st_reg.ir);                                      // RULE_02
   assign ea = (st_reg.ir[6:0] == ADR_INDF) ? st_reg.fsr
             : {st_reg.status[ST_BANK], st_reg.ir[6:0]};                  // RULE_05
   assign ext = !rcd_sfr_hit(ea[6:0]);
   assign pcl_wr = d.to_f && !ext && (ea[6:0] == ADR_PCL);
   assign phase_one = (st_reg.q == RCD_PH1);
   assign phase_two = (st_reg.q == RCD_PH2);
   assign phase_three = (st_reg.q == RCD_PH3);
   assign phase_four = (st_reg.q == RCD_PH4);

   // special registers read through the data space
   always_comb begin
      case (ea[6:0])
         ADR_PCL:    sfr_val = st_reg.pc[7:0];                            // RULE_04
         ADR_STATUS: sfr_val = st_reg.status;
         ADR_FSR:    sfr_val = st_reg.fsr;
         ADR_PCLATH: sfr_val = {3'h0, st_reg.pclath};
         default:    sfr_val = 8'h00;
      endcase
   end

   // second operand: literal or file register; first is always the accumulator
   assign opnd = d.lit ? st_reg.ir[7:0] : (ext ? data_rdata : sfr_val);   // RULE_08 RULE_09

   rcd_alu u_alu (
      .op     (d.op),
      .a      (st_reg.w),
      .b      (opnd),
      .c_in   (st_reg.status[ST_C]),
      .y      (alu_y),
      .c_out  (alu_c),
      .dc_out (alu_dc),
      .z_out  (alu_z)
   );                                                                     // RULE_06 RULE_07

   // phase sequencer, fetch and execute pipeline
   always_comb begin
      st_next = st_reg;
      st_next.master_clear_n_s1 = master_clear_n;
      st_next.master_clear_n_s2 = st_reg.master_clear_n_s1;
      // mode decided once per cycle, so a change never leaves a short pulse
      st_next.ck = (phase_two && rc_mode) || (phase_three && st_reg.ck);  // RULE_13
      case (st_reg.q)
         RCD_PH1: begin
            st_next.q = RCD_PH2;
            st_next.paddr = st_reg.pc;                                    // RULE_01
            st_next.pc = st_reg.pc + 13'h0001;                            // RULE_15
            st_next.daddr = ea;
            st_next.rd = d.rd && ext;                                     // RULE_16
         end
         RCD_PH2: begin
            st_next.q = RCD_PH3;
            st_next.rd = 1'b0;
         end
         RCD_PH3: begin
            st_next.q = RCD_PH4;
            st_next.res = alu_y;
            st_next.c = alu_c;
            st_next.dc = alu_dc;
            st_next.z = alu_z;
            st_next.wr = d.to_f && ext;                                   // RULE_16
            st_next.wdata = alu_y;
         end
         RCD_PH4: begin
            st_next.q = RCD_PH1;
            st_next.wr = 1'b0;
            if (d.to_w) begin
               st_next.w = st_reg.res;                                    // RULE_10
            end
            if (d.to_f && !ext) begin
               case (ea[6:0])
                  ADR_PCL:    st_next.pc = {st_reg.pclath, st_reg.res};   // RULE_04
                  ADR_STATUS: st_next.status = st_reg.res;
                  ADR_FSR:    st_next.fsr = st_reg.res;
                  ADR_PCLATH: st_next.pclath = st_reg.res[4:0];
                  default:    st_next.fsr = st_reg.fsr;
               endcase
            end
            // flags from the unit override a plain write of the status byte
            if (d.fc) begin
               st_next.status[ST_C] = st_reg.c;                           // RULE_11 RULE_12
            end
            if (d.fdc) begin
               st_next.status[ST_DC] = st_reg.dc;                         // RULE_11 RULE_12
            end
            if (d.fz) begin
               st_next.status[ST_Z] = st_reg.z;                           // RULE_18
            end
            if (d.jump) begin
               st_next.pc = {st_reg.pclath[4:3], st_reg.ir[10:0]};
            end
            // prefetched word dropped when the flow changes
            st_next.ir = (d.jump || pcl_wr) ? RCD_NOP : prog_data;        // RULE_03 RULE_17
         end
         default: st_next.q = RCD_PH1;
      endcase
      // master clear held low keeps everything but the synchroniser in reset
      if (!st_reg.master_clear_n_s2) begin
         st_next = CORE_RST;                                              // RULE_14
         st_next.master_clear_n_s1 = master_clear_n;
         st_next.master_clear_n_s2 = st_reg.master_clear_n_s1;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_reg <= CORE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from state
   assign prog_addr = st_reg.paddr;
   assign data_addr = st_reg.daddr;
   assign data_rd_en = st_reg.rd;
   assign data_wr_en = st_reg.wr;
   assign data_wdata = st_reg.wdata;
   assign instruction_rate_clock_out = st_reg.ck;
   assign acc_out = st_reg.w;
   assign status_out = st_reg.status;

   // checks on the running core
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || !st_reg.master_clear_n_s2);

   sequence s_cycle;
      phase_one ##1 phase_two ##1 phase_three ##1 phase_four;
   endsequence
   sequence s_write_slot;
      !data_wr_en ##1 data_wr_en ##1 !data_wr_en;
   endsequence

   a_phase_walk: assert property (phase_one |-> s_cycle) // RULE_15
      else $error("phase order broken");
   a_pc_step: assert property (phase_one |=> (prog_addr == $past(st_reg.pc)) &&
      (st_reg.pc == $past(st_reg.pc) + 13'h0001)) // RULE_15
      else $error("program counter did not step in phase one");
   a_read_slot: assert property (data_rd_en |-> phase_two && $past(phase_one)) // RULE_16
      else $error("operand read outside phase two");
   a_write_slot: assert property (phase_three && d.to_f && ext |-> s_write_slot) // RULE_16
      else $error("destination write outside phase four");
   a_branch_flush: assert property (phase_four && d.jump |=>
      (st_reg.ir == RCD_NOP) && (st_reg.pc[10:0] == $past(st_reg.ir[10:0]))) // RULE_17
      else $error("branch did not flush the prefetch");
   a_fetch_latch: assert property (phase_four && !d.jump && !pcl_wr |=>
      st_reg.ir == $past(prog_data)) // RULE_03
      else $error("fetched word not latched in phase four");
   a_zero_flag: assert property (phase_four && d.fz |=>
      status_out[ST_Z] == ($past(st_reg.res) == 8'h00)) // RULE_18
      else $error("zero flag wrong");
   a_flags_hold: assert property (phase_four && !d.fc && !(d.to_f && !ext &&
      ea[6:0] == ADR_STATUS) |=> $stable(status_out[ST_C])) // RULE_11
      else $error("carry changed by an instruction that keeps it");
   a_sub_borrow: assert property (phase_three && d.op == ALU_SUB |=>
      st_reg.c == ($past(opnd) >= $past(st_reg.w))) // RULE_12
      else $error("borrow sense wrong in subtraction");
   a_clk_quarter: assert property ($rose(instruction_rate_clock_out) |->
      phase_three ##1 instruction_rate_clock_out ##1 !instruction_rate_clock_out) // RULE_13
      else $error("instruction rate clock not a quarter rate");
   a_clear_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !st_reg.master_clear_n_s2 |=> (st_reg.pc == RCD_PC_RST) && !data_wr_en && phase_one) // RULE_14
      else $error("core not held in reset by master clear");
endmodule

// file: bench/rcd_mem_model.sv
// program and data memory model on the two separate buses of the core
`timescale 1ns/1ps
module rcd_mem_model (
   input  logic        clk,
   input  logic        slow,
   input  logic [12:0] prog_addr,
   output logic [13:0] prog_data,
   input  logic [7:0]  data_addr,
   input  logic        data_rd_en,
   input  logic        data_wr_en,
   input  logic [7:0]  data_wdata,
   output logic [7:0]  data_rdata
);
   logic [13:0] rom [0:63];
   logic [7:0]  ram [0:255];
   logic [13:0] word_reg;
   logic [7:0]  rd_reg;
   logic        rd_valid_reg;

   // program word answered at once or one cycle late
   always @(posedge clk) begin
      word_reg <= rom[prog_addr[5:0]];
   end
   assign prog_data = slow ? word_reg : rom[prog_addr[5:0]];

   // data read answered one cycle after the strobe, write taken on the strobe
   always @(posedge clk) begin
      rd_valid_reg <= data_rd_en;
      if (data_rd_en) begin
         rd_reg <= ram[data_addr];
      end
      if (data_wr_en) begin
         ram[data_addr] <= data_wdata;
      end
   end

   // outside the answer cycle the bus never shows the stale byte
   initial rd_reg = 8'h00;
   assign data_rdata = rd_valid_reg ? rd_reg : ~rd_reg;
endmodule

// file: bench/tb_rcd_core.sv
// self-checking bench for the core running small programs from the memory model
`timescale 1ns/1ps
module tb_rcd_core import rcd_pkg::*; ();
   typedef struct packed {
      logic [5:0] op;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] y;
      logic [7:0] st;
   } rcd_case_t;

   logic        clk;
   logic        sys_rst;
   logic        master_clear_n;
   logic        rc_mode;
   logic        slow;
   logic [13:0] prog_data;
   logic [7:0]  data_rdata;
   logic [12:0] prog_addr;
   logic [7:0]  data_addr;
   logic        data_rd_en;
   logic        data_wr_en;
   logic [7:0]  data_wdata;
   logic        instruction_rate_clock_out;
   logic [7:0]  acc_out;
   logic [7:0]  status_out;
   int          num_errors;
   int          total_checks;
   logic [13:0] prog_q [$];
   rcd_case_t   lit_tab [8];
   rcd_case_t   file_tab [8];

   rcd_core i_rcd_core (.clk(clk), .sys_rst(sys_rst), .master_clear_n(master_clear_n),
      .rc_mode(rc_mode), .prog_data(prog_data), .data_rdata(data_rdata),
      .prog_addr(prog_addr), .data_addr(data_addr), .data_rd_en(data_rd_en),
      .data_wr_en(data_wr_en), .data_wdata(data_wdata),
      .instruction_rate_clock_out(instruction_rate_clock_out),
      .acc_out(acc_out), .status_out(status_out));

   rcd_mem_model i_rcd_mem_model (.clk(clk), .slow(slow), .prog_addr(prog_addr),
      .prog_data(prog_data), .data_addr(data_addr), .data_rd_en(data_rd_en),
      .data_wr_en(data_wr_en), .data_wdata(data_wdata), .data_rdata(data_rdata));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // instruction word builders
   function automatic logic [13:0] lw(input logic [5:0] op, input logic [7:0] k);
      return {op, k};
   endfunction
   function automatic logic [13:0] fw(input logic [5:0] op, input logic d, input logic [6:0] f);
      return {op, d, f};
   endfunction
   function automatic logic [13:0] jmp(input logic [10:0] t);
      return {RCD_GOTO_PX, t};
   endfunction

   // compare tasks
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t ns: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic check_word(input logic [13:0] got, input logic [13:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t ns: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // load the program, reset for 3 cycles, then let it run
   task automatic run_prog(input int cycles);
      for (int i = 0; i < 64; i++) begin
         i_rcd_mem_model.rom[i] = (i < prog_q.size()) ? prog_q[i] : RCD_NOP;
      end
      @(negedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(negedge clk);
      sys_rst <= 1'b0;
      repeat (cycles) @(negedge clk);
   endtask

   task automatic tally_and_finish();
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // cuts a hang short
   initial begin
      #(25 * 6000);
      num_errors++;
      tally_and_finish();
   end

   // test sequence
   initial begin
      int   hi;
      int   rises;
      logic prev;
      num_errors = 0;
      total_checks = 0;
      sys_rst = 1'b1;
      master_clear_n = 1'b1;
      rc_mode = 1'b0;
      slow = 1'b0;
      lit_tab = '{'{OP_ADDLW, 8'h0F, 8'h01, 8'h10, 8'h02}, '{OP_ADDLW, 8'hF0, 8'h10, 8'h00, 8'h05},
                  '{OP_SUBLW, 8'h10, 8'h10, 8'h00, 8'h07}, '{OP_SUBLW, 8'h01, 8'h00, 8'hFF, 8'h00},
                  '{OP_ANDLW, 8'hF0, 8'h0F, 8'h00, 8'h04}, '{OP_IORLW, 8'hF0, 8'h0F, 8'hFF, 8'h00},
                  '{OP_XORLW, 8'hFF, 8'hFF, 8'h00, 8'h04}, '{OP_MOVLW, 8'h12, 8'h34, 8'h34, 8'h00}};
      file_tab = '{'{OP_COM, 8'h0F, 8'h00, 8'hF0, 8'h00}, '{OP_INC, 8'hFF, 8'h00, 8'h00, 8'h04},
                   '{OP_DEC, 8'h01, 8'h00, 8'h00, 8'h04}, '{OP_RRF, 8'h01, 8'h00, 8'h00, 8'h01},
                   '{OP_RLF, 8'h81, 8'h00, 8'h02, 8'h01}, '{OP_SWAP, 8'hA5, 8'h00, 8'h5A, 8'h00},
                   '{OP_MOVF, 8'h00, 8'h00, 8'h00, 8'h04}, '{OP_CLR, 8'h77, 8'h00, 8'h00, 8'h04}};
      // accumulator with literal, every literal opcode, memory prompt and slow
      foreach (lit_tab[i]) begin
         slow <= i[0];
         prog_q = '{lw(OP_MOVLW, lit_tab[i].a), lw(lit_tab[i].op, lit_tab[i].b), jmp(11'h002)};
         run_prog(40);
         check_byte(acc_out, lit_tab[i].y);
         check_byte(status_out, lit_tab[i].st);
      end
      // single-operand on a file register, result to accumulator
      foreach (file_tab[i]) begin
         slow <= i[0];
         i_rcd_mem_model.ram[8'h22] = file_tab[i].a;
         prog_q = '{fw(file_tab[i].op, 1'b0, 7'h22), jmp(11'h001)};
         run_prog(40);
         check_byte(acc_out, file_tab[i].y);
         check_byte(status_out, file_tab[i].st);
         check_byte(i_rcd_mem_model.ram[8'h22], file_tab[i].a);
      end
      // add into a file register, carry kept by a later logic op
      prog_q = '{lw(OP_MOVLW, 8'h10), fw(OP_MOVWF, 1'b1, 7'h20), lw(OP_MOVLW, 8'hFF),
                 fw(OP_ADD, 1'b1, 7'h20), lw(OP_ANDLW, 8'h00), jmp(11'h005)};
      run_prog(60);
      check_byte(i_rcd_mem_model.ram[8'h20], 8'h0F);
      check_byte(status_out, 8'h05);
      // indirect access through the pointer register
      i_rcd_mem_model.ram[8'h21] = 8'hFF;
      prog_q = '{lw(OP_MOVLW, 8'h21), fw(OP_MOVWF, 1'b1, 7'h04), fw(OP_COM, 1'b0, 7'h00),
                 fw(OP_INC, 1'b1, 7'h00), jmp(11'h004)};
      run_prog(50);
      check_byte(acc_out, 8'h00);
      check_byte(i_rcd_mem_model.ram[8'h21], 8'h00);
      check_byte(status_out, 8'h04);
      // a jump drops the prefetched word
      prog_q = '{lw(OP_MOVLW, 8'h33), jmp(11'h003), lw(OP_MOVLW, 8'h55), jmp(11'h003)};
      run_prog(50);
      check_byte(acc_out, 8'h33);
      // writing the program counter through its data address
      i_rcd_mem_model.ram[8'h02] = 8'h5A;
      prog_q = '{lw(OP_MOVLW, 8'h05), fw(OP_MOVWF, 1'b1, 7'h02), lw(OP_MOVLW, 8'h11),
                 lw(OP_MOVLW, 8'h11), lw(OP_MOVLW, 8'h11), lw(OP_MOVLW, 8'h77), jmp(11'h006)};
      run_prog(60);
      check_byte(acc_out, 8'h77);
      check_byte(i_rcd_mem_model.ram[8'h02], 8'h5A);
      // clock output at a quarter rate in RC mode, silent otherwise
      for (int m = 1; m >= 0; m--) begin
         rc_mode <= m[0];
         repeat (8) @(negedge clk);
         hi = 0;
         rises = 0;
         prev = instruction_rate_clock_out;
         repeat (80) begin
            @(negedge clk);
            if (instruction_rate_clock_out === 1'b1) hi++;
            if (instruction_rate_clock_out === 1'b1 && prev === 1'b0) rises++;
            prev = instruction_rate_clock_out;
         end
         check_word(14'(hi), m ? 14'h0028 : 14'h0000);
         check_word(14'(rises), m ? 14'h0014 : 14'h0000);
      end
      // master clear held low keeps the core in reset
      master_clear_n <= 1'b0;
      repeat (4) @(negedge clk);
      check_byte(acc_out, 8'h00);
      check_byte(status_out, 8'h00);
      repeat (8) @(negedge clk);
      check_word({1'b0, prog_addr}, 14'h0000);
      master_clear_n <= 1'b1;
      repeat (4) @(negedge clk);
      tally_and_finish();
   end
endmodule
